// >>> src/mbc_regs.sv
/*
 * apb register bank for one master interface bridge; every register
 * is kept or removed by a presence parameter set at build time.
 * assumes a single clock, synchronous apb inputs, zero wait states.
 */
`timescale 1ns/1ns
`default_nettype none

module mbc_regs #(
  parameter bit HAS_SW_ISS = 1'b1,       // bridge sits on a switch
  parameter bit HAS_XSCHEME = 1'b1,      // programmable clock crossing
  parameter bit HAS_SIZING = 1'b1,       // up or downsizing present
  parameter bit HAS_AXI4_DOWN = 1'b1,    // downsizing to axi4
  parameter bit HAS_PROG_VIEW = 1'b1,    // programmers view on
  parameter bit HAS_CHAN_FIFO = 1'b1,    // any channel fifo present
  parameter bit IS_AHB_LITE = 1'b1,      // ahb-lite master interface
  parameter logic [3:0] WR_TIDEMARK = 4'h8 // configured tidemark
) (
  input wire logic clk_i,                       // 20 mhz clock
  input wire logic rstn_i,                      // async reset, low
  input wire mbc_pkg::mbc_apb_req_t apb_req_i,  // apb request
  output logic [31:0] prdata_o,                 // read data
  output logic pready_o,                        // always ready
  output logic pslverr_o,                       // never errors
  output mbc_pkg::mbc_ctrl_t ctrl_o             // controls out
);
  import mbc_pkg::*;

  // ************************************************************
  // presence decisions
  // ************************************************************
  localparam bit EN_SW = HAS_SW_ISS;
  localparam bit EN_XS = HAS_XSCHEME;
  localparam bit EN_MG = HAS_SIZING;
  localparam bit EN_LB = HAS_AXI4_DOWN && HAS_PROG_VIEW;
  // threshold only counts when a non-zero tidemark was built in
  localparam bit EN_WT = HAS_CHAN_FIFO
                         && (WR_TIDEMARK != WTHR_ZERO);
  localparam bit EN_AH = IS_AHB_LITE;
  localparam bit EN_BR = HAS_SIZING || HAS_CHAN_FIFO;

  logic [1:0] sw_iss_ff;
  logic [2:0] xs_ff;
  logic merge_ff;
  logic lb_ff;
  logic [3:0] wthr_ff;
  logic [1:0] ahb_ff;
  logic [1:0] br_iss_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  // decode of the write access phase and the read setup phase
  wire logic wr_acc = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
  wire logic rd_setup = apb_req_i.psel && !apb_req_i.penable
                        && !apb_req_i.pwrite;
  wire logic [11:0] addr = apb_req_i.paddr;
  wire logic [31:0] wd = apb_req_i.pwdata;

  // address hit for a register that is built in
  function automatic logic sel(input logic en, input logic [11:0] a,
      input logic [11:0] base);
    sel = en && (a == base);
  endfunction : sel

  // one hit per register; an absent register never hits
  wire logic hit_sw = sel(EN_SW, addr, ADDR_SW_ISS);
  wire logic hit_xs = sel(EN_XS, addr, ADDR_XSCHEME);
  wire logic hit_mg = sel(EN_MG, addr, ADDR_MERGE);
  wire logic hit_lb = sel(EN_LB, addr, ADDR_LBURST);
  wire logic hit_wt = sel(EN_WT, addr, ADDR_WTHR);
  wire logic hit_ah = sel(EN_AH, addr, ADDR_AHB);
  wire logic hit_br = sel(EN_BR, addr, ADDR_BR_ISS);

  // per register write strobes; every other offset is ignored
  wire logic we_sw = wr_acc && hit_sw;
  wire logic we_xs = wr_acc && hit_xs;
  wire logic we_mg = wr_acc && hit_mg;
  wire logic we_lb = wr_acc && hit_lb;
  wire logic we_wt = wr_acc && hit_wt;
  wire logic we_ah = wr_acc && hit_ah;
  wire logic we_br = wr_acc && hit_br;

  // reserved schemes are refused; the old value stays
  wire logic xs_legal = (wd[2:0] <= MBC_ASYNC);

  // ************************************************************
  // switch issue override
  // ************************************************************
  // force-single bits for the preceding switch arbitration
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sw_iss_ff <= RST_ISS;
    end else if (we_sw) begin
      sw_iss_ff <= wd[1:0];
    end
  end

  // ************************************************************
  // clock crossing scheme
  // ************************************************************
  // reserved codes never land, so the bridge sees a legal scheme
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      xs_ff <= MBC_ASYNC;
    end else if (we_xs && xs_legal) begin
      xs_ff <= wd[2:0];
    end
  end

  // ************************************************************
  // merge bypass
  // ************************************************************
  // single bypass bit for the sizing merge logic
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      merge_ff <= RST_MERGE;
    end else if (we_mg) begin
      merge_ff <= wd[0];
    end
  end

  // ************************************************************
  // long burst control
  // ************************************************************
  // without a programmers view the strobe never fires
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lb_ff <= RST_LBURST;
    end else if (we_lb) begin
      lb_ff <= wd[0];
    end
  end

  // ************************************************************
  // write fifo threshold
  // ************************************************************
  // resets to the build-time tidemark, not a fixed value
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wthr_ff <= WR_TIDEMARK;
    end else if (we_wt) begin
      wthr_ff <= wd[3:0];
    end
  end

  // ************************************************************
  // ahb-lite control
  // ************************************************************
  // decode error enable and forced incrementing bursts
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ahb_ff <= RST_AHB;
    end else if (we_ah) begin
      ahb_ff <= wd[1:0];
    end
  end

  // ************************************************************
  // bridge issue override
  // ************************************************************
  // force-single bits for the bridge's own issuing
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      br_iss_ff <= RST_ISS;
    end else if (we_br) begin
      br_iss_ff <= wd[1:0];
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // read words, unused upper bits zero
  wire logic [31:0] rw_sw = {30'h0, sw_iss_ff};
  wire logic [31:0] rw_xs = {29'h0, xs_ff};
  wire logic [31:0] rw_mg = {31'h0, merge_ff};
  wire logic [31:0] rw_lb = {31'h0, lb_ff};
  wire logic [31:0] rw_wt = {28'h0, wthr_ff};
  wire logic [31:0] rw_ah = {30'h0, ahb_ff};
  wire logic [31:0] rw_br = {30'h0, br_iss_ff};

  // read mux, absent or reserved words give zero
  always_comb begin
    nxt_rdata = RDATA_ZERO;
    if (!rd_setup) nxt_rdata = rdata_ff;
    else if (hit_sw) nxt_rdata = rw_sw;
    else if (hit_xs) nxt_rdata = rw_xs;
    else if (hit_mg) nxt_rdata = rw_mg;
    else if (hit_lb) nxt_rdata = rw_lb;
    else if (hit_wt) nxt_rdata = rw_wt;
    else if (hit_ah) nxt_rdata = rw_ah;
    else if (hit_br) nxt_rdata = rw_br;
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) rdata_ff <= RDATA_ZERO;
    else rdata_ff <= nxt_rdata;
  end

  assign prdata_o = rdata_ff;
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;

  // ************************************************************
  // controls to the bridge and switch
  // ************************************************************
  // level outputs; clearing a bit only affects later issue decisions
  assign ctrl_o.sw_rd_single = EN_SW && sw_iss_ff[ISS_RD_BIT];
  assign ctrl_o.sw_wr_single = EN_SW && sw_iss_ff[ISS_WR_BIT];
  assign ctrl_o.scheme = EN_XS ? xs_ff : MBC_ASYNC;
  assign ctrl_o.merge_bypass = EN_MG && merge_ff;
  assign ctrl_o.long_burst_en = EN_LB && lb_ff;
  assign ctrl_o.wr_threshold = EN_WT ? wthr_ff : WR_TIDEMARK;
  assign ctrl_o.ahb_decerr_en = EN_AH && ahb_ff[AHB_DECERR_BIT];
  assign ctrl_o.ahb_force_incr = EN_AH && ahb_ff[AHB_INCR_BIT];
  assign ctrl_o.br_rd_single = EN_BR && br_iss_ff[ISS_RD_BIT];
  assign ctrl_o.br_wr_single = EN_BR && br_iss_ff[ISS_WR_BIT];

endmodule : mbc_regs

`default_nettype wire

// >>> src/mbc_pkg.sv
/*
 * constants, field layouts and carrier types for the master bridge
 * configuration register bank.
 * assumes an apb slave port with 32-bit data and a 12-bit byte address.
 */
// Functional notes
// - switch issue override register exists only when bridge sits on a switch.
// - switch override bit 0 limits reads, bit 1 writes, to one outstanding.
// - crossing scheme register exists only with programmable clock crossing.
// - scheme 0 1:1, 1 m:1, 2 1:n, 3 m:n, 4 async; 5-7 reserved; resets async.
// - merge bypass bit exists only with up or downsizing; resets to zero.
// - long burst register exists only when downsizing to axi4.
// - long burst bit 0 breaks long bursts; 1 allows long bursts out.
// - without programmers view long burst holds default; no long bursts.
// - write threshold effective only with a configured non-zero fifo tidemark.
// - write threshold resets to the configured tidemark, not a constant.
// - ahb control only for ahb-lite, reset zero; bit0 decode err, bit1 incr.
// - bridge issue override exists with sizing or fifo; bit0 reads, bit1 writes.
package mbc_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [11:0] ADDR_SW_ISS = 12'h008;
  localparam logic [11:0] ADDR_XSCHEME = 12'h020;
  localparam logic [11:0] ADDR_MERGE = 12'h024;
  localparam logic [11:0] ADDR_LBURST = 12'h02c;
  localparam logic [11:0] ADDR_WTHR = 12'h040;
  localparam logic [11:0] ADDR_AHB = 12'h044;
  localparam logic [11:0] ADDR_BR_ISS = 12'h108;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [1:0] RST_ISS = 2'h0;
  localparam logic [0:0] RST_MERGE = 1'h0;
  localparam logic [0:0] RST_LBURST = 1'h0;
  localparam logic [1:0] RST_AHB = 2'h0;
  localparam int ISS_RD_BIT = 0;
  localparam int ISS_WR_BIT = 1;
  localparam int AHB_DECERR_BIT = 0;
  localparam int AHB_INCR_BIT = 1;
  localparam logic [3:0] WTHR_ZERO = 4'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // crossing schemes
  typedef enum logic [2:0] {
    MBC_SYNC_1_1 = 3'b000,
    MBC_SYNC_M_1 = 3'b001,
    MBC_SYNC_1_N = 3'b010,
    MBC_SYNC_M_N = 3'b011,
    MBC_ASYNC = 3'b100
  } mbc_scheme_t;

  // apb request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mbc_apb_req_t;

  // controls handed to the bridge and the switch arbitration
  typedef struct packed {
    logic sw_rd_single;
    logic sw_wr_single;
    logic [2:0] scheme;
    logic merge_bypass;
    logic long_burst_en;
    logic [3:0] wr_threshold;
    logic ahb_decerr_en;
    logic ahb_force_incr;
    logic br_rd_single;
    logic br_wr_single;
  } mbc_ctrl_t;

endpackage : mbc_pkg

// >>> verif/mbc_regs_props.sv
/* assertions on the apb port and control outputs of mbc_regs.
   assumes mbc_regs is built with its default parameters. */
`timescale 1ns/1ns
`default_nettype none
module mbc_regs_chk (
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset, low
  input wire mbc_pkg::mbc_apb_req_t apb_req_i, // request
  input wire logic [31:0] prdata_o, // read data
  input wire logic pready_o, // ready
  input wire logic pslverr_o, // error
  input wire mbc_pkg::mbc_ctrl_t ctrl_o // controls
);
  import mbc_pkg::*;
  // ********************
  // access decode and properties
  // ********************
  wire logic [11:0] a = apb_req_i.paddr;
  wire logic [31:0] d = apb_req_i.pwdata;
  wire logic wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
  wire logic rd = apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_resp; pready_o & ~pslverr_o; endproperty
  a_resp: assert property (p_resp) else $error("bad response");
  property p_sw; wr && a == ADDR_SW_ISS |=>
    {ctrl_o.sw_wr_single, ctrl_o.sw_rd_single} == $past(d[1:0]); endproperty
  a_sw: assert property (p_sw) else $error("switch override");
  property p_sch; wr && a == ADDR_XSCHEME && d[2:0] < 3'h5 |=>
    ctrl_o.scheme == $past(d[2:0]); endproperty
  a_sch: assert property (p_sch) else $error("scheme write");
  property p_rsch; wr && a == ADDR_XSCHEME && d[2:0] > 3'h4 |=>
    $stable(ctrl_o.scheme); endproperty
  a_rsch: assert property (p_rsch) else $error("reserved scheme");
  property p_lb; wr && a == ADDR_LBURST |=>
    ctrl_o.long_burst_en == $past(d[0]); endproperty
  a_lb: assert property (p_lb) else $error("long burst");
  property p_ahb; wr && a == ADDR_AHB |=>
    {ctrl_o.ahb_force_incr, ctrl_o.ahb_decerr_en} == $past(d[1:0]);
  endproperty
  a_ahb: assert property (p_ahb) else $error("ahb control");
  property p_rsv; wr && a == 12'h028 |=> $stable(ctrl_o); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved write");
  property p_rz; rd && a == 12'h028 |=> prdata_o == RDATA_ZERO; endproperty
  a_rz: assert property (p_rz) else $error("reserved read");
endmodule : mbc_regs_chk
bind mbc_regs mbc_regs_chk chk_u (.clk_i, .rstn_i, .apb_req_i, .prdata_o,
  .pready_o, .pslverr_o, .ctrl_o);
`default_nettype wire

// >>> verif/mbc_far_model.sv
/* far side model: issuing limits of switch arbitration and bridge.
   assumes ctrl_i comes straight from mbc_regs. */
`timescale 1ns/1ns
`default_nettype none
module mbc_far_model #(
  parameter logic [3:0] CAP = 4'h4 // normal issuing depth
) (
  input wire mbc_pkg::mbc_ctrl_t ctrl_i, // controls in
  output logic [3:0] rd_cap_o, // reads allowed
  output logic [3:0] wr_cap_o // writes allowed
);
  import mbc_pkg::*;
  // ********************
  // issuing limits, one when forced
  // ********************
  assign rd_cap_o = (ctrl_i.sw_rd_single | ctrl_i.br_rd_single) ? 4'h1
                    : CAP;
  assign wr_cap_o = (ctrl_i.sw_wr_single | ctrl_i.br_wr_single) ? 4'h1
                    : CAP;
endmodule : mbc_far_model
`default_nettype wire

// >>> verif/master_bridge_config_regs_test.sv
/* register tests for mbc_regs over apb, far side model attached.
   assumes default build parameters, tidemark 8. */
`timescale 1ns/1ns
`default_nettype none
module master_bridge_config_regs_test;
  import mbc_pkg::*;
  // ********************
  // bench state and tasks
  // ********************
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  mbc_apb_req_t req = '0;
  mbc_ctrl_t ctrl;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] rd_cap, wr_cap;
  int errors = 0;
  int checks_done = 0;
  logic [11:0] ad [7] = '{ADDR_SW_ISS, ADDR_XSCHEME, ADDR_MERGE, ADDR_LBURST,
    ADDR_WTHR, ADDR_AHB, ADDR_BR_ISS};
  logic [3:0] rv [7] = '{4'h0, 4'h4, 4'h0, 4'h0, 4'h8, 4'h0, 4'h0};
  logic [3:0] wv [7] = '{4'h3, 4'h3, 4'h1, 4'h1, 4'hb, 4'h3, 4'h3};
  always #25 clk_i = ~clk_i;
  mbc_regs dut_u (.clk_i, .rstn_i, .apb_req_i(req), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ctrl_o(ctrl));
  mbc_far_model far_u (.ctrl_i(ctrl), .rd_cap_o(rd_cap), .wr_cap_o(wr_cap));
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    q = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    req <= '0;
    @(posedge clk_i);
  endtask : xfer
  task automatic wrrd(input logic [11:0] a, input logic [31:0] d, e);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
    xfer(1'b0, a, 32'h0, q);
    chk("readback", e, q);
  endtask : wrrd
  task automatic t_reset();
    logic [31:0] q;
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, ad[i], 32'h0, q);
      chk("reset value", {28'h0, rv[i]}, q);
    end
    chk("reset ctrl", {17'h0, 2'b00, 3'h4, 2'b00, 4'h8, 4'h0},
      {17'h0, ctrl});
    $display("test reset done");
  endtask : t_reset
  task automatic t_rw();
    for (int i = 0; i < 7; i++)
      wrrd(ad[i], 32'hffff_fffb, {28'h0, wv[i]});
    chk("ctrl out", {17'h0, 2'b11, 3'h3, 2'b11, 4'hb, 4'hf},
      {17'h0, ctrl});
    chk("read cap", 32'h1, rd_cap);
    wrrd(ADDR_SW_ISS, 32'h0, 32'h0);
    wrrd(ADDR_BR_ISS, 32'h0, 32'h0);
    chk("write cap", 32'h4, wr_cap);
    $display("test readwrite done");
  endtask : t_rw
  task automatic t_sch();
    logic [2:0] cur;
    cur = 3'h3;
    for (int v = 0; v < 8; v++) begin
      if (v < 5) cur = v[2:0];
      wrrd(ADDR_XSCHEME, 32'(v), {29'h0, cur});
      chk("scheme out", {29'h0, cur}, ctrl.scheme);
    end
    $display("test scheme done");
  endtask : t_sch
  task automatic t_rsv();
    logic [31:0] q;
    logic [11:0] rs [5] = '{12'h000, 12'h00c, 12'h028, 12'h100, 12'hffc};
    foreach (rs[i]) wrrd(rs[i], 32'hffff_ffff, 32'h0);
    xfer(1'b0, ADDR_WTHR, 32'h0, q);
    chk("undisturbed", 32'hb, q);
    $display("test reserved done");
  endtask : t_rsv
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // reset, then the tests in order
  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_rw();
    t_sch();
    t_rsv();
    conclude();
  end
  // watchdog against a hung transfer
  initial begin
    #1000000;
    errors++;
    conclude();
  end
endmodule : master_bridge_config_regs_test
`default_nettype wire
